// file: verilog/tsens_i2c_pkg.sv
package tsens_i2c_pkg;

  // Target addresses selected by the strap level.
  localparam logic [6:0] ADDR_STRAP_LOW   = 7'h48;
  localparam logic [6:0] ADDR_STRAP_FLOAT = 7'h49;
  localparam logic [6:0] ADDR_STRAP_HIGH  = 7'h4a;

  // Strap sense codes presented on the two strap sense inputs.
  localparam logic [1:0] STRAP_LOW   = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;

  // Special bus bytes.
  localparam logic [7:0] ALERT_RESP_BYTE = 8'h19;
  localparam logic [6:0] GEN_CALL_ADDR   = 7'h00;
  localparam logic [7:0] GC_RELATCH_CMD  = 8'h04;
  localparam logic [7:0] GC_RESET_CMD    = 8'h06;
  localparam logic [4:0] HS_CODE_PREFIX  = 5'h01;
  localparam int         HS_CODE_MSB     = 7;
  localparam int         HS_CODE_LSB     = 3;

  // Glitch filter spans; the filter is a longest time, so it rounds down.
  localparam int CLK_MHZ        = 100;
  localparam int FILT_FAST_NS   = 50;
  localparam int FILT_HS_NS     = 10;
  localparam int FILT_FAST_RAW  = FILT_FAST_NS * CLK_MHZ / 1000;
  localparam int FILT_HS_RAW    = FILT_HS_NS * CLK_MHZ / 1000;
  localparam logic [2:0] FILT_FAST_CYC = 3'(FILT_FAST_RAW < 1 ? 1 : FILT_FAST_RAW);
  localparam logic [2:0] FILT_HS_CYC   = 3'(FILT_HS_RAW < 1 ? 1 : FILT_HS_RAW);

  // Cycles between reset release and the first strap capture (synchroniser depth plus one).
  localparam logic [1:0] STRAP_WAIT_CYC = 2'h3;

  // Default register pointer after reset.
  localparam logic [7:0] PTR_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RX    = 3'b001,
    ST_ACK   = 3'b010,
    ST_TX    = 3'b011,
    ST_TXACK = 3'b100,
    ST_WAIT  = 3'b101
  } tgt_state_e;

  typedef enum logic [1:0] {
    K_ADDR  = 2'b00,
    K_PTR   = 2'b01,
    K_DATA  = 2'b10,
    K_GCCMD = 2'b11
  } rx_kind_e;

endpackage

// file: verilog/tsens_i2c_target.sv
// Contract
// - Strap level picks one of three addresses.
// - Addressed target pulls SDA low on ninth clock.
// - First write byte loads the register pointer.
// - Reads use last pointer; pointer kept until write or general call reset.
// - Acknowledge address, pointer and each data byte.
// - Transmit pointed register MSB first, then LSB.
// - Alert response byte acked, own address returned.
// - Returned address LSB gives alert cause, polarity.
// - Arbitrate address; winner clears alert at completion.
// - Alert response answered only in interrupt mode.
// - Acknowledge general call with write direction.
// - General call 04 relatches strap, no reset.
// - General call 06 relatches strap, resets registers.
// - Power-on reset restores default settings.
// - Master code unacked, filters switch to high speed.
// - High speed holds until STOP, then fast mode.
// - Interrupt alert holds until read, alert response or general call reset.
// - Strap sampled at reset or relatch, then latched.
// - Bytes shift most significant bit first.
module tsens_i2c_target
  import tsens_i2c_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic [1:0]  addr_strap_pin_i,
  input  wire logic        interrupt_mode_select_i,
  input  wire logic        alert_polarity_i,
  input  wire logic        comparator_status_bit_i,
  input  wire logic        alert_event_i,
  input  wire logic        alert_cause_low_i,
  input  wire logic [15:0] rd_data_i,
  output logic [7:0]       reg_ptr_o,
  output logic             ptr_load_o,
  output logic [7:0]       wr_data_o,
  output logic             wr_valid_o,
  output logic             wr_msb_o,
  output logic             rd_strobe_o,
  output logic             gc_reset_o,
  output logic             hs_mode_o,
  output logic             alert_o,
  output logic [6:0]       dev_addr_o
);

  function automatic logic [6:0] strap_to_addr(input logic [1:0] s);
    logic [6:0] a;
    a = ADDR_STRAP_HIGH;
    if (s == STRAP_LOW) begin
      a = ADDR_STRAP_LOW;
    end else if (s == STRAP_FLOAT) begin
      a = ADDR_STRAP_FLOAT;
    end
    return a;
  endfunction

  logic       scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q;
  logic [1:0] strap_s1_q, strap_s2_q;
  logic       scl_f_q, sda_f_q, scl_prev_q, sda_prev_q;
  logic [2:0] scl_cnt_q, sda_cnt_q, filt_len;
  logic       scl_rise, scl_fall, start_w, stop_w;
  tgt_state_e state_q, nxt_q;
  rx_kind_e   kind_q;
  logic [7:0] shreg_q, tx_q, ptr_q;
  logic [2:0] cnt_q;
  logic       full_q, first_q, ara_q, lsb_next_q, hs_q, sda_oe_q;
  logic       byte_end, own_addr, own_wr, own_rd, gc_hit, ara_hit, hs_hit;
  logic       wr_valid_q, wr_msb_q, ptr_load_q, rd_strobe_q, gc_reset_q;
  logic       relatch_q, ara_win_q, alert_pend_q, cause_low_q;
  logic [1:0] strap_wait_q;
  logic [6:0] dev_addr_q;
  logic [7:0] ara_byte, rd_byte;

  // SCL, SDA and the strap pins each pass two flip-flops before anything looks at them.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      scl_s1_q   <= 1'b1;
      scl_s2_q   <= 1'b1;
      sda_s1_q   <= 1'b1;
      sda_s2_q   <= 1'b1;
      strap_s1_q <= STRAP_LOW;
      strap_s2_q <= STRAP_LOW;
    end else begin
      scl_s1_q   <= scl_i;
      scl_s2_q   <= scl_s1_q;
      sda_s1_q   <= sda_i;
      sda_s2_q   <= sda_s1_q;
      strap_s1_q <= addr_strap_pin_i;
      strap_s2_q <= strap_s1_q;
    end
  end

  // Filter span shrinks in high speed so short pulses still pass.
  assign filt_len = hs_q ? FILT_HS_CYC : FILT_FAST_CYC;

  // Glitch filters: a new level must persist for filt_len samples.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      scl_f_q   <= 1'b1;
      sda_f_q   <= 1'b1;
      scl_cnt_q <= 3'h0;
      sda_cnt_q <= 3'h0;
    end else begin
      if (scl_s2_q == scl_f_q) begin
        scl_cnt_q <= 3'h0;
      end else if (scl_cnt_q + 3'h1 >= filt_len) begin
        scl_f_q   <= scl_s2_q;
        scl_cnt_q <= 3'h0;
      end else begin
        scl_cnt_q <= scl_cnt_q + 3'h1;
      end
      if (sda_s2_q == sda_f_q) begin
        sda_cnt_q <= 3'h0;
      end else if (sda_cnt_q + 3'h1 >= filt_len) begin
        sda_f_q   <= sda_s2_q;
        sda_cnt_q <= 3'h0;
      end else begin
        sda_cnt_q <= sda_cnt_q + 3'h1;
      end
    end
  end

  // Edge history of the filtered lines.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_f_q;
      sda_prev_q <= sda_f_q;
    end
  end

  // SDA moving while SCL is high is a START or STOP, never data.
  assign scl_rise = scl_f_q & ~scl_prev_q;
  assign scl_fall = ~scl_f_q & scl_prev_q;
  assign start_w  = scl_f_q & scl_prev_q & sda_prev_q & ~sda_f_q;
  assign stop_w   = scl_f_q & scl_prev_q & ~sda_prev_q & sda_f_q;

  // Decode of a completed first byte; decided on the falling edge after bit eight.
  assign byte_end = (state_q == ST_RX) && scl_fall && full_q;
  assign own_addr = shreg_q[7:1] == dev_addr_q;
  assign own_wr   = own_addr && !shreg_q[0];
  assign own_rd   = own_addr && shreg_q[0];
  // General call only with the write direction.
  assign gc_hit   = (shreg_q[7:1] == GEN_CALL_ADDR) && !shreg_q[0];
  // Alert response needs interrupt mode and a pending alert.
  assign ara_hit  = (shreg_q == ALERT_RESP_BYTE) && interrupt_mode_select_i && alert_pend_q;
  assign hs_hit   = first_q && (shreg_q[HS_CODE_MSB:HS_CODE_LSB] == HS_CODE_PREFIX);
  // Cause bit is low for the high limit under active-low polarity.
  assign ara_byte = {dev_addr_q, cause_low_q ^ alert_polarity_i};
  assign rd_byte  = lsb_next_q ? rd_data_i[7:0] : rd_data_i[15:8];

  // Protocol engine: receive, acknowledge, transmit and arbitration.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_q     <= ST_IDLE;
      nxt_q       <= ST_IDLE;
      kind_q      <= K_ADDR;
      shreg_q     <= 8'h00;
      tx_q        <= 8'h00;
      cnt_q       <= 3'h0;
      full_q      <= 1'b0;
      first_q     <= 1'b0;
      ara_q       <= 1'b0;
      lsb_next_q  <= 1'b0;
      hs_q        <= 1'b0;
      sda_oe_q    <= 1'b0;
      ptr_q       <= PTR_RESET;
      wr_valid_q  <= 1'b0;
      wr_msb_q    <= 1'b1;
      ptr_load_q  <= 1'b0;
      rd_strobe_q <= 1'b0;
      gc_reset_q  <= 1'b0;
      relatch_q   <= 1'b0;
      ara_win_q   <= 1'b0;
    end else begin
      wr_valid_q  <= 1'b0;
      ptr_load_q  <= 1'b0;
      rd_strobe_q <= 1'b0;
      gc_reset_q  <= 1'b0;
      relatch_q   <= 1'b0;
      ara_win_q   <= 1'b0;
      if (gc_reset_q) begin
        ptr_q <= PTR_RESET;
      end
      if (start_w) begin
        state_q  <= ST_RX;
        kind_q   <= K_ADDR;
        cnt_q    <= 3'h0;
        full_q   <= 1'b0;
        first_q  <= 1'b1;
        ara_q    <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (stop_w) begin
        // STOP returns the filters to fast mode.
        state_q  <= ST_IDLE;
        hs_q     <= 1'b0;
        sda_oe_q <= 1'b0;
      end else begin
        unique case (state_q)
          ST_IDLE, ST_WAIT: begin
            sda_oe_q <= 1'b0;
          end
          ST_RX: begin
            if (scl_rise) begin
              shreg_q <= {shreg_q[6:0], sda_f_q};
              cnt_q   <= cnt_q + 3'h1;
              full_q  <= cnt_q == 3'h7;
            end else if (byte_end) begin
              full_q  <= 1'b0;
              first_q <= 1'b0;
              cnt_q   <= 3'h0;
              state_q <= ST_ACK;
              nxt_q   <= ST_RX;
              // Acknowledge by default; refused cases release below.
              sda_oe_q <= 1'b1;
              unique case (kind_q)
                K_ADDR: begin
                  if (hs_hit) begin
                    hs_q     <= 1'b1;
                    sda_oe_q <= 1'b0;
                    state_q  <= ST_WAIT;
                  end else if (own_wr) begin
                    kind_q <= K_PTR;
                  end else if (own_rd) begin
                    // Read starts at the stored pointer, pointer untouched.
                    rd_strobe_q <= 1'b1;
                    lsb_next_q  <= 1'b0;
                    nxt_q       <= ST_TX;
                  end else if (gc_hit) begin
                    kind_q <= K_GCCMD;
                  end else if (ara_hit) begin
                    // Answer the alert response with own address.
                    ara_q <= 1'b1;
                    nxt_q <= ST_TX;
                  end else begin
                    sda_oe_q <= 1'b0;
                    state_q  <= ST_WAIT;
                  end
                end
                K_PTR: begin
                  // First byte after a write address is the pointer.
                  ptr_q      <= shreg_q;
                  ptr_load_q <= 1'b1;
                  wr_msb_q   <= 1'b1;
                  kind_q     <= K_DATA;
                end
                K_DATA: begin
                  wr_valid_q <= 1'b1;
                  wr_msb_q   <= ~wr_msb_q;
                end
                K_GCCMD: begin
                  if (shreg_q == GC_RELATCH_CMD) begin
                    relatch_q <= 1'b1;
                    nxt_q     <= ST_WAIT;
                  end else if (shreg_q == GC_RESET_CMD) begin
                    relatch_q  <= 1'b1;
                    gc_reset_q <= 1'b1;
                    nxt_q      <= ST_WAIT;
                  end else begin
                    sda_oe_q <= 1'b0;
                    state_q  <= ST_WAIT;
                  end
                end
              endcase
            end
          end
          ST_ACK: begin
            // Release or load only after SCL falls, so hold time is kept.
            if (scl_fall) begin
              state_q <= nxt_q;
              cnt_q   <= 3'h0;
              if (nxt_q == ST_TX) begin
                tx_q       <= ara_q ? ara_byte : rd_byte;
                sda_oe_q   <= ara_q ? ~ara_byte[7] : ~rd_byte[7];
                lsb_next_q <= ara_q ? lsb_next_q : ~lsb_next_q;
              end else begin
                sda_oe_q <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_rise && tx_q[7] && !sda_f_q) begin
              // Lost arbitration: go quiet and keep the alert.
              state_q  <= ST_WAIT;
              sda_oe_q <= 1'b0;
            end else if (scl_fall) begin
              if (cnt_q == 3'h7) begin
                sda_oe_q <= 1'b0;
                state_q  <= ST_TXACK;
                // Whole address sent without loss: this target won.
                ara_win_q <= ara_q;
              end else begin
                tx_q     <= {tx_q[6:0], 1'b0};
                sda_oe_q <= ~tx_q[6];
                cnt_q    <= cnt_q + 3'h1;
              end
            end
          end
          ST_TXACK: begin
            if (scl_rise) begin
              // Master ack asks for the next byte; NACK ends the read.
              state_q <= (!sda_f_q && !ara_q) ? ST_ACK : ST_WAIT;
              nxt_q   <= ST_TX;
            end
          end
          default: begin
            state_q  <= ST_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Strap captured once synchronised after reset, and on relatch only.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      strap_wait_q <= STRAP_WAIT_CYC;
      dev_addr_q   <= ADDR_STRAP_LOW;
    end else begin
      if (strap_wait_q != 2'h0) begin
        strap_wait_q <= strap_wait_q - 2'h1;
      end
      if (strap_wait_q == 2'h1 || relatch_q) begin
        dev_addr_q <= strap_to_addr(strap_s2_q);
      end
    end
  end

  // Interrupt alert latch; a new event wins over a same-cycle clear.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      alert_pend_q <= 1'b0;
      cause_low_q  <= 1'b0;
    end else if (alert_event_i && interrupt_mode_select_i) begin
      alert_pend_q <= 1'b1;
      cause_low_q  <= alert_cause_low_i;
    end else if (rd_strobe_q || ara_win_q || gc_reset_q) begin
      alert_pend_q <= 1'b0;
    end
  end

  // All flops above take defaults on reset. Open-drain: only ever drive low.
  assign sda_o       = 1'b0;
  assign sda_oe_o    = sda_oe_q;
  assign reg_ptr_o   = ptr_q;
  assign ptr_load_o  = ptr_load_q;
  assign wr_data_o   = shreg_q;
  assign wr_valid_o  = wr_valid_q;
  assign wr_msb_o    = ~wr_msb_q;
  assign rd_strobe_o = rd_strobe_q;
  assign gc_reset_o  = gc_reset_q;
  assign hs_mode_o   = hs_q;
  assign dev_addr_o  = dev_addr_q;
  // Alert pin is active low unless polarity is set.
  assign alert_o = alert_polarity_i ~^ (interrupt_mode_select_i ? alert_pend_q
                                                                 : comparator_status_bit_i);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  ack_own_addr_a: assert property (byte_end && kind_q == K_ADDR && own_wr && !hs_hit
    |=> sda_oe_o && state_q == ST_ACK) else $error("address not acked");
  ack_hold_a: assert property (state_q == ST_ACK && sda_oe_o && !scl_fall && !start_w
    && !stop_w |=> sda_oe_o) else $error("ack released early");
  ptr_load_a: assert property (byte_end && kind_q == K_PTR
    |=> ptr_load_o && reg_ptr_o == $past(shreg_q)) else $error("pointer not loaded");
  ptr_hold_a: assert property ($changed(reg_ptr_o)
    |-> $past(ptr_load_q) || ptr_load_o || $past(gc_reset_q)) else $error("pointer moved");
  msb_first_a: assert property (state_q == ST_ACK && nxt_q == ST_TX && scl_fall
    && !ara_q && !lsb_next_q |=> tx_q == $past(rd_data_i[15:8])) else $error("msb not first");
  ara_lsb_a: assert property (state_q == ST_ACK && nxt_q == ST_TX && scl_fall && ara_q
    |=> tx_q == {dev_addr_q, $past(cause_low_q ^ alert_polarity_i)}) else $error("bad cause");
  ara_mode_a: assert property (byte_end && kind_q == K_ADDR && !hs_hit && !own_addr
    && !gc_hit && !interrupt_mode_select_i |=> !sda_oe_o) else $error("alert answered");
  gc_reset_a: assert property (byte_end && kind_q == K_GCCMD && shreg_q == GC_RESET_CMD
    |=> gc_reset_o && relatch_q ##1 reg_ptr_o == PTR_RESET) else $error("reset missed");
  hs_noack_a: assert property (byte_end && kind_q == K_ADDR && hs_hit
    |=> !sda_oe_o && hs_mode_o) else $error("master code mishandled");
  hs_stop_a: assert property (stop_w |=> !hs_mode_o) else $error("hs kept after stop");
  alert_hold_a: assert property (alert_pend_q && !rd_strobe_q && !ara_win_q
    && !gc_reset_q |=> alert_pend_q) else $error("alert dropped");
  strap_latch_a: assert property (relatch_q
    |=> dev_addr_o == strap_to_addr($past(strap_s2_q))) else $error("strap not latched");

  read_cov: cover property (rd_strobe_o ##[1:1000] (state_q == ST_TXACK));
  write_cov: cover property (ptr_load_o ##[1:1000] wr_valid_o);
  ara_cov: cover property (ara_win_q);
  hs_cov: cover property (hs_mode_o ##[1:1000] stop_w);

endmodule

// file: testbench/bus_master.sv
// Behavioural controller on the two-wire bus; it pulls SDA low or leaves it to the pull-up.
module bus_master (
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // Fast frames run slower than the link rate, because the slow input filter needs it.
  realtime t_set;
  realtime t_low;
  realtime t_high;

  // SCL stands high and SDA is released between frames.
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    t_set = 100.3;
    t_low = 50.0;
    t_high = 99.7;
  end

  // Selects high-speed or fast bit timing.
  task automatic set_hs(input logic hs);
    t_set = hs ? 45.1 : 100.3;
    t_low = hs ? 17.4 : 50.0;
    t_high = hs ? 62.5 : 99.7;
  endtask

  // A start, or a repeated start when SCL is low: SDA falls while SCL is high.
  task automatic start();
    #(t_set) sda_low_o = 1'b0;
    #(t_low) scl_o = 1'b1;
    #(t_high) sda_low_o = 1'b1;
    #(t_high) scl_o = 1'b0;
  endtask

  // A stop: SDA rises while SCL is high.
  task automatic stop();
    #(t_set) sda_low_o = 1'b1;
    #(t_low) scl_o = 1'b1;
    #(t_high) sda_low_o = 1'b0;
    #(t_high);
  endtask

  // SDA moves only while SCL is low; the bit is read at the end of SCL high.
  task automatic xfer_bit(input logic b, output logic r);
    #(t_set) sda_low_o = ~b;
    #(t_low) scl_o = 1'b1;
    #(t_high) r = sda_i;
    scl_o = 1'b0;
  endtask

  // Bytes go out most significant bit first, then the ack slot is read.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(b[i], r);
    end
    xfer_bit(1'b1, r);
    ack = ~r;
  endtask

  // A read byte is closed by ack or not-ack; fight mimics a rival target at 0.
  task automatic recv_byte(input logic ack_it, input logic fight, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(~fight, d[i]);
    end
    xfer_bit(~ack_it, r);
  endtask
endmodule

// file: testbench/tsens_i2c_target_bench.sv
module tsens_i2c_target_bench;
  import tsens_i2c_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [1:0] strap;
    logic [6:0] addr;
  } row_s;

  logic        clk_i, rst_b_i, scl, m_low, sda_bus, sda_o, sda_oe_o;
  logic        tm, alert_polarity, cmp, ev, cause, ptr_load, wr_valid, wr_msb;
  logic        rd_strobe, gc_reset, hs_mode, alert;
  logic [1:0]  strap;
  logic [15:0] rd_data;
  logic [7:0]  reg_ptr, wr_data;
  logic [6:0]  dev_addr, own;
  logic [8:0]  wr_q[$];
  int          n_rd, n_gc, n_ptr, cycles, mismatches, n_checks;
  row_s        rows[4] = '{'{STRAP_LOW, ADDR_STRAP_LOW}, '{STRAP_FLOAT, ADDR_STRAP_FLOAT},
                           '{2'h2, ADDR_STRAP_HIGH}, '{2'h3, ADDR_STRAP_HIGH}};

  // Open-drain SDA with a pull-up: low when either party pulls.
  assign sda_bus = ~(m_low | (sda_oe_o & ~sda_o));

  tsens_i2c_target tsens_i2c_target_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl),
    .sda_i(sda_bus), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_strap_pin_i(strap),
    .interrupt_mode_select_i(tm), .alert_polarity_i(alert_polarity), .comparator_status_bit_i(cmp),
    .alert_event_i(ev), .alert_cause_low_i(cause), .rd_data_i(rd_data),
    .reg_ptr_o(reg_ptr), .ptr_load_o(ptr_load), .wr_data_o(wr_data),
    .wr_valid_o(wr_valid), .wr_msb_o(wr_msb), .rd_strobe_o(rd_strobe),
    .gc_reset_o(gc_reset), .hs_mode_o(hs_mode), .alert_o(alert), .dev_addr_o(dev_addr));

  bus_master bus_master_i (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda_bus));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // The register file mirror answers with the pointer and its inverse.
  always @(negedge clk_i) begin
    rd_data <= {reg_ptr, ~reg_ptr};
  end

  // Pulses are counted so that a missing or doubled pulse shows up.
  always @(posedge clk_i) begin
    if (wr_valid === 1'b1) wr_q.push_back({wr_msb, wr_data});
    if (rd_strobe === 1'b1) n_rd++;
    if (gc_reset === 1'b1) n_gc++;
    if (ptr_load === 1'b1) n_ptr++;
    cycles++;
    if (cycles > 40000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic tx(input logic [7:0] b, input logic exp_ack);
    logic a;
    bus_master_i.send_byte(b, a);
    check(16'(a), 16'(exp_ack), "ack slot");
  endtask

  task automatic rx(input logic ack_it, input logic fight, input logic [7:0] exp);
    logic [7:0] d;
    bus_master_i.recv_byte(ack_it, fight, d);
    check(16'(d), 16'(exp), "read byte");
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Raises one alert event with the given cause and polarity.
  task automatic raise(input logic p, input logic c);
    @(negedge clk_i);
    alert_polarity = p;
    cause = c;
    ev = 1'b1;
    @(negedge clk_i);
    ev = 1'b0;
    idle(2);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    rst_b_i = 1'b0;
    strap = STRAP_FLOAT;
    {tm, alert_polarity, cmp, ev, cause} = 5'h00;
    rd_data = 16'h0000;
    idle(10);
    check(16'(dev_addr), 16'(ADDR_STRAP_LOW), "reset address");
    check(16'(reg_ptr), 16'(PTR_RESET), "reset pointer");
    check(16'({hs_mode, sda_oe_o}), 16'h0000, "reset hs and sda");
    idle(6);
    rst_b_i = 1'b1;
    idle(8);
    check(16'(dev_addr), 16'(ADDR_STRAP_FLOAT), "strap capture");
    strap = 2'h2;
    idle(8);
    check(16'(dev_addr), 16'(ADDR_STRAP_FLOAT), "strap latched");
    // Strap rows: relatch through general call, then the new address must answer.
    foreach (rows[i]) begin
      @(negedge clk_i);
      strap = rows[i].strap;
      bus_master_i.start();
      tx({GEN_CALL_ADDR, 1'b0}, 1'b1);
      tx(GC_RELATCH_CMD, 1'b1);
      bus_master_i.stop();
      idle(4);
      check(16'(dev_addr), 16'(rows[i].addr), "strap row");
      bus_master_i.start();
      tx({rows[i].addr, 1'b0}, 1'b1);
      bus_master_i.stop();
    end
    check(16'(n_gc), 16'h0000, "relatch resets nothing");
    own = ADDR_STRAP_HIGH;
    bus_master_i.start();
    tx({ADDR_STRAP_LOW, 1'b0}, 1'b0);
    bus_master_i.stop();
    // Write pointer and two data bytes, close by repeated start, read back.
    bus_master_i.start();
    tx({own, 1'b0}, 1'b1);
    tx(8'h5a, 1'b1);
    tx(8'hc3, 1'b1);
    tx(8'h3c, 1'b1);
    bus_master_i.start();
    tx({own, 1'b1}, 1'b1);
    rx(1'b1, 1'b0, 8'h5a);
    rx(1'b0, 1'b0, 8'ha5);
    bus_master_i.stop();
    idle(4);
    check(16'(n_ptr), 16'h0001, "pointer loads");
    check(16'(wr_q.size()), 16'h0002, "bytes written");
    check(16'(wr_q[0]), 16'h01c3, "first data byte");
    check(16'(wr_q[1]), 16'h003c, "second data byte");
    // A second read with no pointer reuses it and wraps to the high byte.
    bus_master_i.start();
    tx({own, 1'b1}, 1'b1);
    rx(1'b1, 1'b0, 8'h5a);
    rx(1'b1, 1'b0, 8'ha5);
    rx(1'b0, 1'b0, 8'h5a);
    bus_master_i.stop();
    idle(4);
    check(16'(reg_ptr), 16'h005a, "pointer kept");
    check(16'(n_rd), 16'h0002, "read strobes");
    // Pointer-only write, then a restart read.
    bus_master_i.start();
    tx({own, 1'b0}, 1'b1);
    tx(8'h21, 1'b1);
    bus_master_i.start();
    tx({own, 1'b1}, 1'b1);
    rx(1'b0, 1'b0, 8'h21);
    bus_master_i.stop();
    // Alert below the low limit, active low, answered and cleared.
    @(negedge clk_i) tm = 1'b1;
    raise(1'b0, 1'b1);
    check(16'(alert), 16'h0000, "alert active low");
    bus_master_i.start();
    tx(ALERT_RESP_BYTE, 1'b1);
    rx(1'b0, 1'b0, {own, 1'b1});
    bus_master_i.stop();
    idle(4);
    check(16'(alert), 16'h0001, "alert cleared by response");
    // High limit, active high: lost arbitration keeps it, a win clears it.
    raise(1'b1, 1'b0);
    check(16'(alert), 16'h0001, "alert active high");
    bus_master_i.start();
    tx(ALERT_RESP_BYTE, 1'b1);
    rx(1'b0, 1'b1, 8'h00);
    bus_master_i.stop();
    idle(4);
    check(16'(alert), 16'h0001, "alert kept after loss");
    bus_master_i.start();
    tx(ALERT_RESP_BYTE, 1'b1);
    rx(1'b0, 1'b0, {own, 1'b1});
    bus_master_i.stop();
    idle(4);
    check(16'(alert), 16'h0000, "alert cleared after win");
    // Comparator mode refuses the query; a register read clears the alert.
    raise(1'b1, 1'b1);
    tm = 1'b0;
    cmp = 1'b1;
    idle(1);
    check(16'(alert), 16'h0001, "comparator alert");
    cmp = 1'b0;
    bus_master_i.start();
    tx(ALERT_RESP_BYTE, 1'b0);
    bus_master_i.stop();
    @(negedge clk_i) tm = 1'b1;
    bus_master_i.start();
    tx({own, 1'b1}, 1'b1);
    rx(1'b0, 1'b0, 8'h21);
    bus_master_i.stop();
    idle(4);
    check(16'(alert), 16'h0000, "alert cleared by read");
    bus_master_i.start();
    tx(ALERT_RESP_BYTE, 1'b0);
    bus_master_i.stop();
    // General call reset with a new strap level.
    strap = STRAP_LOW;
    bus_master_i.start();
    tx({GEN_CALL_ADDR, 1'b0}, 1'b1);
    tx(GC_RESET_CMD, 1'b1);
    bus_master_i.stop();
    idle(4);
    own = ADDR_STRAP_LOW;
    check(16'(n_gc), 16'h0001, "reset pulse");
    check(16'(reg_ptr), 16'(PTR_RESET), "pointer reset");
    check(16'(dev_addr), 16'(own), "strap relatched");
    // Master code, then high-speed frames until the stop.
    bus_master_i.start();
    tx(8'h0d, 1'b0);
    bus_master_i.set_hs(1'b1);
    idle(2);
    check(16'(hs_mode), 16'h0001, "high speed on");
    bus_master_i.start();
    tx({own, 1'b0}, 1'b1);
    tx(8'h33, 1'b1);
    bus_master_i.start();
    tx({own, 1'b1}, 1'b1);
    rx(1'b0, 1'b0, 8'h33);
    check(16'(hs_mode), 16'h0001, "high speed kept");
    bus_master_i.stop();
    bus_master_i.set_hs(1'b0);
    idle(4);
    check(16'(hs_mode), 16'h0000, "high speed off");
    // A second reset in mid-run must drop a pending alert and the pointer.
    raise(1'b1, 1'b0);
    check(16'(alert), 16'h0001, "alert before reset");
    rst_b_i = 1'b0;
    strap = STRAP_FLOAT;
    idle(16);
    rst_b_i = 1'b1;
    idle(8);
    check(16'(reg_ptr), 16'(PTR_RESET), "pointer after reset");
    check(16'(alert), 16'h0000, "alert after reset");
    check(16'(dev_addr), 16'(ADDR_STRAP_FLOAT), "address after reset");
    end_of_test();
  end
endmodule
